// file: src/gpr_defs.svh
// Offsets, field positions, reset values and masks of the GPIO register block.
// Assumes inclusion by bare name; definitions only.
`ifndef GPR_DEFS_SVH
`define GPR_DEFS_SVH

// Register indices; byte address is four times the index
`define GPR_IDX_P6_PIN0_CFG 8'h47
`define GPR_IDX_P6_PIN1_CFG 8'h48
`define GPR_IDX_PORT1_DATA 8'h4B
`define GPR_IDX_PORT2_DATA 8'h4C
`define GPR_IDX_PORT3_DATA 8'h4D
`define GPR_IDX_PORT4_DATA 8'h4E
`define GPR_IDX_PORT5_DATA 8'h4F
`define GPR_IDX_PORT6_DATA 8'h50

// Bus geometry
`define GPR_ADDR_W 12
`define GPR_PORT_N 6
`define GPR_PIN_N 48

// Configuration register fields
`define GPR_CFG_DIR 0
`define GPR_CFG_POL 1
`define GPR_CFG_ALT_LO 2
`define GPR_CFG_OD 7
`define GPR_CFG_MASK 8'h8F
`define GPR_CFG_RST 8'h01

// Data registers
`define GPR_DATA_RST 8'h00
`define GPR_PORT3_MAIN_BIT 3
`define GPR_PORT3_SLOT 2
// Pins that exist, port 6 in the top byte down to port 1 in the low byte
`define GPR_PIN_VALID 48'h03FF0FFFF7FF

`endif

// file: src/gpr_pkg.sv
// Types shared by the GPIO register block.
// Assumes gpr_defs.svh is on the include path.
package gpr_pkg;

   // Alternate function select of a port-6 configuration register
   typedef enum logic [1:0] {
      ALT_GPIO = 2'b00,
      ALT_LED = 2'b01,
      ALT_IRQ = 2'b10,
      ALT_RSVD = 2'b11
   } gpr_alt_t;

   // Bus data phase state
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } gpr_bus_t;

endpackage

// file: src/gpr_pin_if.sv
// Per-pin control and pin levels between register logic and pin bank.
// Assumes one clock domain; vectors indexed 8*(port-1)+bit.
`timescale 1ns/100ps
`include "gpr_defs.svh"
interface gpr_pin_if;
   logic [`GPR_PIN_N-1:0] isInput;
   logic [`GPR_PIN_N-1:0] invert;
   logic [`GPR_PIN_N-1:0] openDrain;
   logic [`GPR_PIN_N-1:0] drvData;
   logic [`GPR_PIN_N-1:0] pinIn;
   logic [`GPR_PIN_N-1:0] pinOut;
   logic [`GPR_PIN_N-1:0] pinOe;
   logic [`GPR_PIN_N-1:0] level;

   modport bank (
      input isInput, invert, openDrain, drvData, pinIn,
      output pinOut, pinOe, level
   );

   modport ctrl (
      output isInput, invert, openDrain, drvData, pinIn,
      input pinOut, pinOe, level
   );
endinterface

// file: src/gpr_pin_bank.sv
// Pin drivers: polarity, direction and driver type for every pin.
// Assumes pin inputs are synchronous to ref_clk.
`timescale 1ns/100ps
`include "gpr_defs.svh"
module gpr_pin_bank import gpr_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Pin control
   gpr_pin_if.bank pins
);

   genvar i;
   generate
      for (i = 0; i < `GPR_PIN_N; i++) begin : g_pin
         logic lvl;
         assign lvl = pins.drvData[i] ^ pins.invert[i]; // RULE_02

         // Input level as seen by software
         assign pins.level[i] = pins.pinIn[i] ^ pins.invert[i]; // RULE_02

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               pins.pinOut[i] <= 1'b0;
               pins.pinOe[i] <= 1'b0;
            end else if (pins.isInput[i]) begin
               pins.pinOut[i] <= 1'b0; // RULE_01
               pins.pinOe[i] <= 1'b0; // RULE_01
            end else if (pins.openDrain[i]) begin
               pins.pinOut[i] <= 1'b0; // RULE_04
               pins.pinOe[i] <= ~lvl; // RULE_04
            end else begin
               pins.pinOut[i] <= lvl; // RULE_04
               pins.pinOe[i] <= 1'b1; // RULE_04
            end
         end
      end
   endgenerate

endmodule

// file: src/gpr_top.sv
// GPIO register block: port-6 pin configuration and six port data registers.
// Assumes an AHB-Lite master with single word transfers, one clock ref_clk.
// What this block does
// [RULE_01] Config bit 0: one input, zero output
// [RULE_02] Config bit 1 inverts pin versus data
// [RULE_03] Pin 6.1 alt: GPIO, indicator B, irq 5
// [RULE_04] Config bit 7 open drain, else push-pull
// [RULE_05] Port 1 data bits map pins 0-7
// [RULE_06] Port 2 data, bit 3 has no pin
// [RULE_07] Port 3 data, bit 3 also main resets
// [RULE_08] Port 4 data, upper nibble reserved
// [RULE_09] Port 5 data bits map pins 0-7
// [RULE_10] Port 6 data bits 0,1 only
// [RULE_11] Pin 6.0 alt: indicator A, irq 4
// [RULE_12] Read gives input level of input pins, data register of output pins; write drives outputs
`timescale 1ns/100ps
`include "gpr_defs.svh"
module gpr_top import gpr_pkg::*; (
   // Clock and standby-power reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Main-power and hard resets, synchronous, active low
   input wire logic mainPowerResetN,
   input wire logic hardResetN,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [`GPR_ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Configuration of pins outside port 6
   input wire logic [`GPR_PIN_N-1:0] extPinIsInput,
   input wire logic [`GPR_PIN_N-1:0] extPinInvert,
   input wire logic [`GPR_PIN_N-1:0] extPinOpenDrain,
   // Indicator sources and edge events
   input wire logic indicatorSrcA,
   input wire logic indicatorSrcB,
   output logic irqEdge4,
   output logic irqEdge5,
   // Port 1 pins
   input wire logic [7:0] port1PinIn,
   output logic [7:0] port1PinOut,
   output logic [7:0] port1PinOe,
   // Port 2 pins
   input wire logic [7:0] port2PinIn,
   output logic [7:0] port2PinOut,
   output logic [7:0] port2PinOe,
   // Port 3 pins
   input wire logic [7:0] port3PinIn,
   output logic [7:0] port3PinOut,
   output logic [7:0] port3PinOe,
   // Port 4 pins
   input wire logic [7:0] port4PinIn,
   output logic [7:0] port4PinOut,
   output logic [7:0] port4PinOe,
   // Port 5 pins
   input wire logic [7:0] port5PinIn,
   output logic [7:0] port5PinOut,
   output logic [7:0] port5PinOe,
   // Port 6 pins
   input wire logic [1:0] port6PinIn,
   output logic [1:0] port6PinOut,
   output logic [1:0] port6PinOe
);

   localparam logic [`GPR_PIN_N-1:0] PinValid = `GPR_PIN_VALID;

   gpr_pin_if pins ();

   // Bus capture
   gpr_bus_t busState_q;
   logic [7:0] busIdx_q;
   logic accept;
   logic [7:0] addrIdx;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic wrStrobe;

   // Registers
   logic [7:0] cfgReg_q [0:1];
   logic [7:0] dataReg_q [0:`GPR_PORT_N-1];
   logic [`GPR_PIN_N-1:0] dataFlat;
   logic [7:0] readByte;

   // Edge detection on interrupt pins
   logic [1:0] irqLevelPrev_q;
   logic [1:0] irqMode;
   logic irqEdge4_q;
   logic irqEdge5_q;

   assign accept = hsel & htrans[1] & hready;
   assign addrIdx = haddr[9:2];
   assign wrStrobe = (busState_q == BUS_WRITE);

   // Address phase and data phase sequencing
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busState_q <= BUS_IDLE;
         busIdx_q <= 8'h00;
         hreadyout_q <= 1'b1;
      end else begin
         case (busState_q)
            BUS_IDLE, BUS_WRITE: begin
               if (accept && hwrite) begin
                  busState_q <= BUS_WRITE;
                  busIdx_q <= addrIdx;
                  hreadyout_q <= 1'b1;
               end else if (accept) begin
                  busState_q <= BUS_READ;
                  busIdx_q <= addrIdx;
                  hreadyout_q <= 1'b0;
               end else begin
                  busState_q <= BUS_IDLE;
                  hreadyout_q <= 1'b1;
               end
            end
            BUS_READ: begin
               busState_q <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
            default: begin
               busState_q <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   // Read data captured at the end of the wait cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_q <= 32'h00000000;
      end else if (busState_q == BUS_READ) begin
         hrdata_q <= {24'h000000, readByte};
      end
   end

   // Port-6 configuration registers
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_cfg
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               cfgReg_q[c] <= `GPR_CFG_RST;
            end else if (wrStrobe && busIdx_q == `GPR_IDX_P6_PIN0_CFG + 8'(c)) begin
               cfgReg_q[c] <= hwdata[7:0] & `GPR_CFG_MASK; // RULE_04
            end
         end
      end
   endgenerate

   // Port data registers; reserved bits never stored
   genvar p;
   generate
      for (p = 0; p < `GPR_PORT_N; p++) begin : g_data
         logic [7:0] mask;
         logic hit;
         assign mask = PinValid[8*p +: 8]; // RULE_05 RULE_06 RULE_08 RULE_09 RULE_10
         assign hit = wrStrobe && busIdx_q == `GPR_IDX_PORT1_DATA + 8'(p);
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               dataReg_q[p] <= `GPR_DATA_RST;
            end else if (hit) begin
               dataReg_q[p] <= hwdata[7:0] & mask; // RULE_12
               if (p == `GPR_PORT3_SLOT && (!mainPowerResetN || !hardResetN)) begin
                  dataReg_q[p][`GPR_PORT3_MAIN_BIT] <= 1'b0; // RULE_07
               end
            end else if (p == `GPR_PORT3_SLOT && (!mainPowerResetN || !hardResetN)) begin
               dataReg_q[p][`GPR_PORT3_MAIN_BIT] <= 1'b0; // RULE_07
            end
         end
         assign dataFlat[8*p +: 8] = dataReg_q[p];
      end
   endgenerate

   // Alternate function of the two port-6 pins
   always_comb begin
      pins.isInput = extPinIsInput | ~PinValid;
      pins.invert = extPinInvert;
      pins.openDrain = extPinOpenDrain;
      pins.drvData = dataFlat;
      irqMode = 2'b00;
      for (int k = 0; k < 2; k++) begin
         pins.invert[40+k] = cfgReg_q[k][`GPR_CFG_POL]; // RULE_02
         pins.openDrain[40+k] = cfgReg_q[k][`GPR_CFG_OD]; // RULE_04
         case (gpr_alt_t'(cfgReg_q[k][`GPR_CFG_ALT_LO +: 2]))
            ALT_GPIO: begin
               pins.isInput[40+k] = cfgReg_q[k][`GPR_CFG_DIR]; // RULE_01
            end
            ALT_LED: begin
               pins.isInput[40+k] = 1'b0; // RULE_03 RULE_11
               pins.drvData[40+k] = (k == 0) ? indicatorSrcA : indicatorSrcB; // RULE_03 RULE_11
            end
            ALT_IRQ: begin
               pins.isInput[40+k] = 1'b1; // RULE_03 RULE_11
               irqMode[k] = 1'b1; // RULE_03 RULE_11
            end
            default: begin
               pins.isInput[40+k] = 1'b1;
            end
         endcase
      end
   end

   assign pins.pinIn = {6'h00, port6PinIn, port5PinIn, port4PinIn,
                        port3PinIn, port2PinIn, port1PinIn};

   gpr_pin_bank u_bank (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pins(pins)
   );

   // Read multiplexer
   always_comb begin
      readByte = 8'h00;
      if (busIdx_q == `GPR_IDX_P6_PIN0_CFG) begin
         readByte = cfgReg_q[0];
      end else if (busIdx_q == `GPR_IDX_P6_PIN1_CFG) begin
         readByte = cfgReg_q[1];
      end else begin
         for (int q = 0; q < `GPR_PORT_N; q++) begin
            if (busIdx_q == `GPR_IDX_PORT1_DATA + 8'(q)) begin
               for (int b = 0; b < 8; b++) begin
                  readByte[b] = PinValid[8*q+b] &
                     (pins.isInput[8*q+b] ? pins.level[8*q+b] : dataReg_q[q][b]); // RULE_12
               end
            end
         end
      end
   end

   // Either-edge event pulses for the two interrupt inputs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irqLevelPrev_q <= 2'b00;
         irqEdge4_q <= 1'b0;
         irqEdge5_q <= 1'b0;
      end else begin
         irqLevelPrev_q <= pins.level[41:40];
         irqEdge4_q <= irqMode[0] & (pins.level[40] ^ irqLevelPrev_q[0]); // RULE_11
         irqEdge5_q <= irqMode[1] & (pins.level[41] ^ irqLevelPrev_q[1]); // RULE_03
      end
   end

   // Outputs
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign irqEdge4 = irqEdge4_q;
   assign irqEdge5 = irqEdge5_q;
   assign port1PinOut = pins.pinOut[7:0];
   assign port1PinOe = pins.pinOe[7:0];
   assign port2PinOut = pins.pinOut[15:8];
   assign port2PinOe = pins.pinOe[15:8];
   assign port3PinOut = pins.pinOut[23:16];
   assign port3PinOe = pins.pinOe[23:16];
   assign port4PinOut = pins.pinOut[31:24];
   assign port4PinOe = pins.pinOe[31:24];
   assign port5PinOut = pins.pinOut[39:32];
   assign port5PinOe = pins.pinOe[39:32];
   assign port6PinOut = pins.pinOut[41:40];
   assign port6PinOe = pins.pinOe[41:40];

   logic unusedBits;
   assign unusedBits = ^{hsize, haddr[`GPR_ADDR_W-1:10], haddr[1:0], hwdata[31:8],
                         pins.pinOut[47:42], pins.pinOe[47:42]};

endmodule

// file: bench/gpr_top_props.sv
// Bus timing and pin drive checks for the GPIO register block.
// Assumes one clock and the asynchronous reset reset_n.
`timescale 1ns/100ps
`include "gpr_defs.svh"
module gpr_top_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Bus
   input wire logic hsel,
   input wire logic [`GPR_ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Pins
   input wire logic [`GPR_PIN_N-1:0] extPinIsInput,
   input wire logic [`GPR_PIN_N-1:0] extPinOpenDrain,
   input wire logic [7:0] port1PinOut,
   input wire logic [7:0] port1PinOe,
   input wire logic [7:0] port2PinOe,
   input wire logic [7:0] port4PinOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_rd;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence s_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rdwait; s_rd |=> s_ans; endproperty
   a_rdwait: assert property (p_rdwait) else $error("read answer timing");
   property p_wr; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
   a_wr: assert property (p_wr) else $error("write stalled");
   property p_unmap; s_rd ##0 (haddr[11:2] == 10'h0) |-> ##2 hrdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_rdhi; hreadyout |-> hrdata[31:8] == 24'h0 && !hresp; endproperty
   a_rdhi: assert property (p_rdhi) else $error("read upper bits or response");
   property p_rsv2; !port2PinOe[3]; endproperty
   a_rsv2: assert property (p_rsv2) else $error("port 2 bit 3 driven");
   property p_rsv4; port4PinOe[7:4] == 4'h0; endproperty
   a_rsv4: assert property (p_rsv4) else $error("port 4 upper pins driven");
   property p_od;
      $past(extPinOpenDrain[0]) && $past(extPinOpenDrain[0], 2) |-> !port1PinOut[0];
   endproperty
   a_od: assert property (p_od) else $error("open drain drives high");
   property p_in;
      $past(extPinIsInput[0]) && $past(extPinIsInput[0], 2) |-> !port1PinOe[0];
   endproperty
   a_in: assert property (p_in) else $error("input pin driven");
endmodule
bind gpr_top gpr_top_props u_props (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .extPinIsInput, .extPinOpenDrain, .port1PinOut,
   .port1PinOe, .port2PinOe, .port4PinOe);

// file: bench/gpr_pin_model.sv
// Board side of the pins: pull-ups and outside drivers.
// Assumes vectors indexed 8*(port-1)+bit.
`timescale 1ns/100ps
module gpr_pin_model (
   // Design drive
   input wire logic [47:0] pinOut,
   input wire logic [47:0] pinOe,
   // Outside drive
   input wire logic [47:0] extVal,
   input wire logic [47:0] extEn,
   // Resolved level
   output logic [47:0] pinLevel
);
   // Design wins; undriven pins pulled up
   assign pinLevel = (pinOe & pinOut) | (~pinOe & ((extEn & extVal) | ~extEn));
endmodule

// file: bench/tb_top.sv
// Self-checking bench: registers over the bus, pins via the pin model.
// Assumes the design sources and gpr_defs.svh on the include path.
`timescale 1ns/100ps
`include "gpr_defs.svh"
module tb_top;
   logic ref_clk = 1'h0, reset_n = 1'h0, mainPowerResetN = 1'h1, hardResetN = 1'h1;
   logic hsel = 1'h1, hwrite = 1'h0, hreadyout, hresp, srcA = 1'h0, srcB = 1'h0, irq4, irq5;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [47:0] isIn = 48'h0, inv = 48'h0, od = 48'h0, extVal = 48'h0, extEn = 48'h0;
   wire [47:0] pOut, pOe, lvl;
   int num_errors = 0, comparisons = 0, n4 = 0, n5 = 0;
   localparam logic [7:0] C0 = `GPR_IDX_P6_PIN0_CFG, C1 = `GPR_IDX_P6_PIN1_CFG;
   localparam logic [7:0] D1 = `GPR_IDX_PORT1_DATA, D6 = `GPR_IDX_PORT6_DATA;
   gpr_top dut (.ref_clk, .reset_n, .mainPowerResetN, .hardResetN, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .extPinIsInput(isIn), .extPinInvert(inv), .extPinOpenDrain(od), .indicatorSrcA(srcA),
      .indicatorSrcB(srcB), .irqEdge4(irq4), .irqEdge5(irq5), .port1PinIn(lvl[7:0]),
      .port1PinOut(pOut[7:0]), .port1PinOe(pOe[7:0]), .port2PinIn(lvl[15:8]),
      .port2PinOut(pOut[15:8]), .port2PinOe(pOe[15:8]), .port3PinIn(lvl[23:16]),
      .port3PinOut(pOut[23:16]), .port3PinOe(pOe[23:16]), .port4PinIn(lvl[31:24]),
      .port4PinOut(pOut[31:24]), .port4PinOe(pOe[31:24]), .port5PinIn(lvl[39:32]),
      .port5PinOut(pOut[39:32]), .port5PinOe(pOe[39:32]), .port6PinIn(lvl[41:40]),
      .port6PinOut(pOut[41:40]), .port6PinOe(pOe[41:40]));
   gpr_pin_model pm (.pinOut(pOut), .pinOe(pOe), .extVal, .extEn, .pinLevel(lvl));
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n4 <= n4 + (irq4 === 1'h1);
      n5 <= n5 + (irq5 === 1'h1);
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic rdy();
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'h1);
   endtask
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
      haddr <= {2'h0, i, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'h1, i, d);
   endtask
   task automatic rc(input string nm, input logic [7:0] i, input logic [7:0] e);
      xfer(1'h0, i, 8'h0);
      chk(nm, rd, {24'h0, e});
   endtask
   task automatic t_reset();
      rc("cfg1", C1, 8'h01);
      for (int i = 0; i < 6; i++) begin
         // Port 6 pins reset as inputs and read the pulled-up level
         rc("data", D1 + 8'(i), (i == 5) ? 8'h03 : 8'h00);
      end
      wr(8'h00, 8'hFF);
      rc("unmap", 8'h00, 8'h00);
   endtask
   task automatic t_ports();
      logic [7:0] m[6] = '{8'hFF, 8'hF7, 8'hFF, 8'h0F, 8'hFF, 8'h03};
      wr(C0, 8'h00);
      wr(C1, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(D1 + 8'(i), 8'hA5);
         cyc(2);
         chk("oe", pOe[8*i+:8] & m[i], m[i]);
         chk("out", pOut[8*i+:8] & m[i], 8'hA5 & m[i]);
         rc("back", D1 + 8'(i), 8'hA5 & m[i]);
      end
      od <= 48'h1;
      cyc(3);
      chk("od1", {pOe[0], pOut[0]}, 2'h0);
   endtask
   task automatic t_pol();
      wr(C1, 8'hFF);
      rc("cfgrsv", C1, 8'h8F);
      wr(C1, 8'h02);
      wr(D6, 8'h02);
      cyc(2);
      chk("inv", {pOe[41], pOut[41]}, 2'h2);
      wr(C1, 8'h80);
      cyc(2);
      chk("odhi", pOe[41], 1'h0);
      wr(D6, 8'h00);
      cyc(2);
      chk("odlo", {pOe[41], pOut[41]}, 2'h2);
   endtask
   task automatic t_in();
      extEn <= 48'h0300000000FF;
      extVal <= 48'h02000000003C;
      isIn <= 48'hFF;
      wr(C1, 8'h01);
      cyc(3);
      rc("p1in", D1, 8'h3C);
      chk("p1oe", pOe[7:0], 8'h0);
      rc("p6in", D6, 8'h02);
      inv <= 48'hFF;
      wr(C1, 8'h03);
      cyc(3);
      rc("p1inv", D1, 8'hC3);
      rc("p6inv", D6, 8'h00);
   endtask
   task automatic t_alt();
      int b4, b5;
      srcA <= 1'h1;
      srcB <= 1'h1;
      wr(C0, 8'h04);
      wr(C1, 8'h04);
      cyc(2);
      chk("leds", {pOe[41:40], pOut[41:40]}, 4'hF);
      extVal[41:40] <= 2'h0;
      wr(C0, 8'h08);
      wr(C1, 8'h08);
      cyc(4);
      b4 = n4;
      b5 = n5;
      extVal[41:40] <= 2'h3;
      cyc(4);
      extVal[41:40] <= 2'h0;
      cyc(4);
      chk("irq4", n4 - b4, 2);
      chk("irq5", n5 - b5, 2);
      wr(C1, 8'h0C);
      cyc(2);
      chk("alt3", pOe[41], 1'h0);
   endtask
   task automatic t_p3();
      for (int k = 0; k < 2; k++) begin
         wr(`GPR_IDX_PORT3_DATA, 8'hFF);
         {mainPowerResetN, hardResetN} <= (k == 0) ? 2'h1 : 2'h2;
         cyc(1);
         {mainPowerResetN, hardResetN} <= 2'h3;
         rc("p3rst", `GPR_IDX_PORT3_DATA, 8'hF7);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #125000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'h1;
      @(posedge ref_clk);
      t_reset();
      t_ports();
      t_pol();
      t_in();
      t_alt();
      t_p3();
      close_out();
   end
endmodule
